// file: logic/xc_pkg.sv
// ----------------------------------------
// shared constants and types
// ----------------------------------------
package xc_pkg;
   localparam int NSRC = 8;
   localparam logic [3:0] SOFT_IDX = 4'h8;
   localparam int DMA_SRC = 7;
   localparam int XFER_CYCLES = 4;
   localparam int CNT_W = 3;
   localparam logic [CNT_W-1:0] CNT_LOAD = 3'(XFER_CYCLES - 1);
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_ACT_EN = 8'h04;
   localparam logic [7:0] A_ACT_SET = 8'h08;
   localparam logic [7:0] A_ACT_CLR = 8'h0c;
   localparam logic [7:0] A_SOFT = 8'h10;
   localparam logic [7:0] A_STAT = 8'h14;
   localparam logic [7:0] A_ICLR = 8'h18;
   localparam logic [7:0] A_IEN = 8'h1c;
   localparam logic [7:0] A_VEC = 8'h20;
   localparam int CTRL_STOP_BIT = 0;
   localparam int CTRL_RAM_BIT = 1;
   localparam int CTRL_BUSY_BIT = 2;
   localparam logic CTRL_STOP_RST = 1'h0;
   localparam logic CTRL_RAM_RST = 1'h1;
   localparam int SOFT_FLAG_BIT = 8;
   localparam int ST_W = 9;
   localparam int VEC_VALID_BIT = 31;

   typedef enum logic [1:0] {XC_IDLE, XC_RUN, XC_DONE} xc_state_t;

   // lowest set bit wins; {valid, index}
   function automatic logic [4:0] xc_first(input logic [15:0] req);
      logic [4:0] res;
      res = 5'h00;
      for (int i = 15; i >= 0; i--) begin
         if (req[i]) begin
            res = {1'b1, 4'(i)};
         end
      end
      return res;
   endfunction
endpackage

// file: logic/xc_if.sv
`timescale 1ns/1ps
// ----------------------------------------
// link between transfer controller and cpu side
// ----------------------------------------
interface xc_if;
   logic [xc_pkg::NSRC-1:0] act_en;
   logic [xc_pkg::NSRC-1:0] act_en_clr;
   logic [xc_pkg::NSRC-1:0] cpu_fwd;
   logic soft_flag;
   logic [7:0] soft_vec;
   logic soft_clr;
   logic soft_end_irq;
   logic stop;
   logic ram_en;
   logic busy;

   modport dev (
      input act_en, soft_flag, soft_vec, stop, ram_en,
      output act_en_clr, cpu_fwd, soft_clr, soft_end_irq, busy
   );
   modport ctl (
      output act_en, soft_flag, soft_vec, stop, ram_en,
      input act_en_clr, cpu_fwd, soft_clr, soft_end_irq, busy
   );
endinterface

// file: logic/xc_xfer_seq.sv
`timescale 1ns/1ps
// ----------------------------------------
// transfer duration counter
// ----------------------------------------
module xc_xfer_seq (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic start,
   output logic done
);
   logic active_r;
   logic [xc_pkg::CNT_W-1:0] cnt_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         active_r <= 1'b0;
         cnt_r <= '0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            active_r <= 1'b1;
            cnt_r <= xc_pkg::CNT_LOAD;
         end else if (active_r) begin
            if (cnt_r == '0) begin
               active_r <= 1'b0;
               done <= 1'b1;
            end else begin
               cnt_r <= cnt_r - 1'b1;
            end
         end
      end
   end
endmodule

// file: logic/xc_dev.sv
`timescale 1ns/1ps
// ----------------------------------------
// transfer controller end interrupt logic
// ----------------------------------------

// Behaviour
// [RULE1] interrupt when count exhausted or select set
// [RULE2] hardware activation forwards its own source interrupt
// [RULE3] forwarded interrupts stay under controller mask, priority
// [RULE4] software activation raises soft end interrupt
// [RULE5] soft end keeps flag set, raises interrupt
// [RULE6] software clears soft flag when servicing
// [RULE7] no soft end interrupt while waiting or running
// [RULE8] stop bit halts controller activity
// [RULE9] stop write ignored while controller busy
// [RULE10] ram enable must stay set while used
// [RULE11] dma source enable never touched by controller; code clears it on interrupt request like the other sources
// [RULE12] enable bits changed by single bit operations
// [RULE13] masked software may write several enables
// [RULE14] interrupt request clears source activation enable
// [RULE15] no interrupt soft transfer clears soft flag
// [RULE16] end interrupt held until software clears
module xc_dev (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [xc_pkg::NSRC-1:0] src_irq,
   input wire logic irq_select,
   input wire logic count_zero,
   output logic [xc_pkg::NSRC-1:0] src_clr,
   output logic xfer_start,
   output logic [3:0] xfer_src,
   output logic [7:0] xfer_vec,
   xc_if.dev lnk
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   xc_pkg::xc_state_t state_r;
   xc_pkg::xc_state_t state_nxt;
   logic [3:0] cur_r;
   logic soft_taken_r;
   logic soft_done_r;
   logic seq_done;
   logic run_ok;
   logic soft_want;
   logic irq_req;
   logic done_now;
   logic done_soft;
   logic [xc_pkg::NSRC-1:0] pend;
   logic [4:0] pick;
   logic [xc_pkg::NSRC-1:0] act_en_clr_r;
   logic [xc_pkg::NSRC-1:0] cpu_fwd_r;
   logic [xc_pkg::NSRC-1:0] src_clr_r;
   logic soft_clr_r;
   logic soft_end_r;
   logic busy_r;

   // ----------------------------------------
   // activation selection
   // ----------------------------------------
   always_comb begin
      run_ok = ~lnk.stop & lnk.ram_en; // RULE8
      pend = lnk.act_en & src_irq & {xc_pkg::NSRC{run_ok}};
      soft_want = lnk.soft_flag & ~soft_taken_r & run_ok;
      pick = xc_pkg::xc_first({7'h00, soft_want, pend});
      irq_req = irq_select | count_zero; // RULE1
      done_now = (state_r == xc_pkg::XC_RUN) && seq_done;
      done_soft = done_now && (cur_r == xc_pkg::SOFT_IDX);
   end

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         xc_pkg::XC_IDLE: begin
            if (pick[4]) begin
               state_nxt = xc_pkg::XC_RUN;
            end
         end
         xc_pkg::XC_RUN: begin
            if (seq_done) begin
               state_nxt = xc_pkg::XC_DONE;
            end
         end
         xc_pkg::XC_DONE: begin
            state_nxt = xc_pkg::XC_IDLE;
         end
         default: begin
            state_nxt = xc_pkg::XC_IDLE;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r <= xc_pkg::XC_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ----------------------------------------
   // transfer launch
   // ----------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cur_r <= 4'h0;
         xfer_start <= 1'b0;
         xfer_src <= 4'h0;
         xfer_vec <= 8'h00;
      end else begin
         xfer_start <= 1'b0;
         if (state_r == xc_pkg::XC_IDLE && pick[4]) begin
            cur_r <= pick[3:0];
            xfer_start <= 1'b1;
            xfer_src <= pick[3:0];
            if (pick[3:0] == xc_pkg::SOFT_IDX) begin
               xfer_vec <= lnk.soft_vec;
            end else begin
               xfer_vec <= {4'h0, pick[3:0]};
            end
         end
      end
   end

   xc_xfer_seq u_seq (
      .hclk(hclk),
      .hresetn(hresetn),
      .start(xfer_start),
      .done(seq_done)
   );

   // ----------------------------------------
   // hardware source completion
   // ----------------------------------------
   for (genvar i = 0; i < xc_pkg::NSRC; i++) begin : g_src
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            act_en_clr_r[i] <= 1'b0;
            src_clr_r[i] <= 1'b0;
            cpu_fwd_r[i] <= 1'b0;
         end else begin
            act_en_clr_r[i] <= done_now && cur_r == 4'(i) && irq_req; // RULE14
            // dma source flag left alone
            src_clr_r[i] <= done_now && cur_r == 4'(i) && !irq_req
                            && i != xc_pkg::DMA_SRC; // RULE11
            // source held, so it reaches cpu once enable drops
            cpu_fwd_r[i] <= src_irq[i] & ~(lnk.act_en[i] & run_ok); // RULE2 RULE16
         end
      end
   end

   // ----------------------------------------
   // software activation end
   // ----------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         soft_taken_r <= 1'b0;
      end else if (state_r == xc_pkg::XC_IDLE && pick[4]
                   && pick[3:0] == xc_pkg::SOFT_IDX) begin
         soft_taken_r <= 1'b1;
      end else if (!lnk.soft_flag) begin
         soft_taken_r <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         soft_done_r <= 1'b0;
      end else if (done_soft && irq_req) begin
         soft_done_r <= 1'b1; // RULE5
      end else if (!lnk.soft_flag) begin
         soft_done_r <= 1'b0; // RULE16
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         soft_clr_r <= 1'b0;
      end else begin
         soft_clr_r <= done_soft && !irq_req; // RULE15
      end
   end

   // only after completion, never during wait or run
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         soft_end_r <= 1'b0;
      end else begin
         soft_end_r <= soft_done_r & lnk.soft_flag; // RULE4 RULE7
      end
   end

   // ----------------------------------------
   // status to controller side
   // ----------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         busy_r <= 1'b0;
      end else begin
         busy_r <= state_nxt != xc_pkg::XC_IDLE; // RULE9
      end
   end

   // forwarded unmasked; controller side applies mask
   assign lnk.cpu_fwd = cpu_fwd_r; // RULE3
   assign lnk.act_en_clr = act_en_clr_r;
   assign lnk.soft_clr = soft_clr_r;
   assign lnk.soft_end_irq = soft_end_r;
   assign lnk.busy = busy_r;
   assign src_clr = src_clr_r;
endmodule

// file: logic/xc_ctl.sv
`timescale 1ns/1ps
// ----------------------------------------
// cpu side: registers, mask and priority
// ----------------------------------------
module xc_ctl (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   output logic irq,
   xc_if.ctl lnk
);
   logic wr_r;
   logic [7:0] wa_r;
   logic stop_r;
   logic ram_r;
   logic [xc_pkg::NSRC-1:0] act_r;
   logic [xc_pkg::NSRC-1:0] act_nxt;
   logic sflag_r;
   logic [7:0] svec_r;
   logic [xc_pkg::ST_W-1:0] stat_r;
   logic [xc_pkg::ST_W-1:0] ien_r;
   logic [xc_pkg::ST_W-1:0] ev;
   logic [xc_pkg::ST_W-1:0] iclr;
   logic [xc_pkg::NSRC-1:0] fwd_q_r;
   logic swe_q_r;
   logic [4:0] vec;
   logic in_use;
   logic [31:0] rd;

   // ----------------------------------------
   // bus slave
   // ----------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_r <= 1'b0;
         wa_r <= 8'h00;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         wr_r <= hsel & htrans[1] & hready & hwrite;
         wa_r <= haddr[7:0];
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         if (hsel & htrans[1] & hready & !hwrite) begin
            hrdata <= rd;
         end
      end
   end

   always_comb begin
      vec = xc_pkg::xc_first({7'h00, stat_r & ien_r});
      in_use = lnk.busy | (|act_r) | sflag_r;
      rd = 32'h0000_0000;
      unique case (haddr[7:0])
         xc_pkg::A_CTRL: rd = {29'h0, lnk.busy, ram_r, stop_r};
         xc_pkg::A_ACT_EN: rd = {24'h0, act_r};
         xc_pkg::A_SOFT: rd = {23'h0, sflag_r, svec_r};
         xc_pkg::A_STAT: rd = {23'h0, stat_r};
         xc_pkg::A_IEN: rd = {23'h0, ien_r};
         xc_pkg::A_VEC: rd = {vec[4], 27'h0, vec[3:0]};
         default: rd = 32'h0000_0000;
      endcase
   end

   // ----------------------------------------
   // control bits
   // ----------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stop_r <= xc_pkg::CTRL_STOP_RST;
         ram_r <= xc_pkg::CTRL_RAM_RST;
      end else if (wr_r && wa_r == xc_pkg::A_CTRL) begin
         if (!(hwdata[xc_pkg::CTRL_STOP_BIT] && lnk.busy)) begin
            stop_r <= hwdata[xc_pkg::CTRL_STOP_BIT]; // RULE8 RULE9
         end
         if (hwdata[xc_pkg::CTRL_RAM_BIT] || !in_use) begin
            ram_r <= hwdata[xc_pkg::CTRL_RAM_BIT]; // RULE10
         end
      end
   end

   // ----------------------------------------
   // activation enables
   // ----------------------------------------
   always_comb begin
      act_nxt = act_r & ~lnk.act_en_clr; // RULE14
      if (wr_r && wa_r == xc_pkg::A_ACT_EN) begin
         act_nxt = hwdata[xc_pkg::NSRC-1:0]; // RULE13
      end else if (wr_r && wa_r == xc_pkg::A_ACT_SET) begin
         act_nxt = act_nxt | hwdata[xc_pkg::NSRC-1:0]; // RULE12
      end else if (wr_r && wa_r == xc_pkg::A_ACT_CLR) begin
         act_nxt = act_nxt & ~hwdata[xc_pkg::NSRC-1:0]; // RULE12
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         act_r <= '0;
      end else begin
         act_r <= act_nxt; // RULE11
      end
   end

   // ----------------------------------------
   // software activation flag
   // ----------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sflag_r <= 1'b0;
         svec_r <= 8'h00;
      end else if (wr_r && wa_r == xc_pkg::A_SOFT) begin
         if (!hwdata[xc_pkg::SOFT_FLAG_BIT]) begin
            sflag_r <= 1'b0; // RULE6
         end else if (!sflag_r || lnk.soft_clr) begin
            sflag_r <= 1'b1;
            svec_r <= hwdata[7:0];
         end
      end else if (lnk.soft_clr) begin
         sflag_r <= 1'b0;
      end
   end

   // ----------------------------------------
   // interrupt status, enable, output
   // ----------------------------------------
   always_comb begin
      ev = {lnk.soft_end_irq & ~swe_q_r, lnk.cpu_fwd & ~fwd_q_r};
      iclr = (wr_r && wa_r == xc_pkg::A_ICLR) ? hwdata[xc_pkg::ST_W-1:0] : '0;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fwd_q_r <= '0;
         swe_q_r <= 1'b0;
         stat_r <= '0;
         ien_r <= '0;
         irq <= 1'b0;
      end else begin
         fwd_q_r <= lnk.cpu_fwd;
         swe_q_r <= lnk.soft_end_irq;
         stat_r <= (stat_r & ~iclr) | ev;
         if (wr_r && wa_r == xc_pkg::A_IEN) begin
            ien_r <= hwdata[xc_pkg::ST_W-1:0];
         end
         irq <= |(stat_r & ien_r); // RULE3
      end
   end

   assign lnk.act_en = act_r;
   assign lnk.soft_flag = sflag_r;
   assign lnk.soft_vec = svec_r;
   assign lnk.stop = stop_r;
   assign lnk.ram_en = ram_r;
endmodule

// file: dv/xc_monitor.sv
`timescale 1ns/1ps
// ----------------------------------------
// link checker
// ----------------------------------------
module xc_monitor (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [7:0] act_en,
   input wire logic [7:0] act_en_clr,
   input wire logic [7:0] cpu_fwd,
   input wire logic soft_flag,
   input wire logic soft_clr,
   input wire logic soft_end_irq,
   input wire logic stop,
   input wire logic busy
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   property p_clr_pulse;
      |act_en_clr |=> act_en_clr == 8'h00;
   endproperty
   property p_clr_takes;
      (act_en_clr & act_en) != 8'h00 |=> (act_en & $past(act_en_clr)) == 8'h00;
   endproperty
   property p_fwd;
      |act_en_clr |-> ##2 (cpu_fwd & $past(act_en_clr, 2)) == $past(act_en_clr, 2);
   endproperty
   property p_fwd_off;
      !$past(stop) |-> (cpu_fwd & ~$past(cpu_fwd) & act_en & $past(act_en)) == 8'h00;
   endproperty
   property p_end_flag;
      $rose(soft_end_irq) |-> soft_flag;
   endproperty
   property p_end_hold;
      soft_end_irq && soft_flag |=> soft_end_irq;
   endproperty
   property p_end_drop;
      $fell(soft_flag) |-> ##[1:2] !soft_end_irq;
   endproperty
   property p_no_early;
      $rose(busy) && soft_flag && !soft_end_irq |=> !soft_end_irq [*3];
   endproperty
   property p_soft_clr;
      soft_clr |=> !soft_flag && !soft_end_irq;
   endproperty
   property p_stop_busy;
      $rose(stop) |-> !$past(busy);
   endproperty
   property p_stop_halt;
      stop |=> !$rose(busy);
   endproperty

   a_clr_pulse: assert property (p_clr_pulse) else $error("enable clear too long");
   a_clr_takes: assert property (p_clr_takes) else $error("enable not cleared");
   a_fwd: assert property (p_fwd) else $error("source irq not forwarded");
   a_fwd_off: assert property (p_fwd_off) else $error("forward while enabled");
   a_end_flag: assert property (p_end_flag) else $error("soft end without flag");
   a_end_hold: assert property (p_end_hold) else $error("soft end dropped early");
   a_end_drop: assert property (p_end_drop) else $error("soft end stuck");
   a_no_early: assert property (p_no_early) else $error("soft end during transfer");
   a_soft_clr: assert property (p_soft_clr) else $error("soft flag kept");
   a_stop_busy: assert property (p_stop_busy) else $error("stop taken while busy");
   a_stop_halt: assert property (p_stop_halt) else $error("start while stopped");

   c_clr: cover property (|act_en_clr);
   c_end: cover property ($rose(soft_end_irq));
   c_sclr: cover property (soft_clr);
endmodule

// file: dv/transfer_controller_end_irq_tb.sv
`timescale 1ns/1ps
// ----------------------------------------
// both ends joined, bus master, peripherals
// ----------------------------------------
module transfer_controller_end_irq_tb;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout, hresp, irq;
   logic irq_select = 1'b0;
   logic count_zero = 1'b0;
   logic [7:0] src_irq = 8'h00;
   logic [7:0] src_set = 8'h00;
   logic [7:0] src_drop = 8'h00;
   logic [7:0] src_clr;
   logic xfer_start;
   logic [3:0] xfer_src;
   logic [7:0] xfer_vec;
   logic [11:0] launch = 12'h000;
   logic [8:0] seen = 9'h000;
   logic seen_rst = 1'b0;
   int fail_count = 0;
   int comparisons = 0;

   xc_if lnk();
   xc_dev i_xc_dev (.hclk(hclk), .hresetn(hresetn), .src_irq(src_irq), .irq_select(irq_select),
      .count_zero(count_zero), .src_clr(src_clr), .xfer_start(xfer_start), .xfer_src(xfer_src),
      .xfer_vec(xfer_vec), .lnk(lnk));
   xc_ctl i_xc_ctl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .irq(irq), .lnk(lnk));
   xc_monitor i_xc_monitor (.hclk(hclk), .hresetn(hresetn), .act_en(lnk.act_en),
      .act_en_clr(lnk.act_en_clr), .cpu_fwd(lnk.cpu_fwd), .soft_flag(lnk.soft_flag),
      .soft_clr(lnk.soft_clr), .soft_end_irq(lnk.soft_end_irq), .stop(lnk.stop),
      .busy(lnk.busy));

   always #12.5 hclk = ~hclk;

   // peripherals drop their flag on request
   always @(posedge hclk) begin
      src_irq <= (src_irq | src_set) & ~src_clr & ~src_drop;
      seen <= seen_rst ? 9'h000 : seen | {lnk.soft_clr, src_clr};
      if (xfer_start) begin
         launch <= {xfer_src, xfer_vec};
      end
   end

   task automatic report_and_stop();
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   function automatic logic fires(input logic s, input logic c);
      return s | c;
   endfunction

   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
         output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= w ? d : 32'h0;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      r = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(a, 1'b1, d, r);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      bus(a, 1'b0, 32'h0, r);
      chk(r, e);
   endtask

   task automatic kick(input logic [7:0] s, input logic [7:0] d);
      src_set <= s;
      src_drop <= d;
      seen_rst <= 1'b1;
      @(posedge hclk);
      src_set <= 8'h00;
      src_drop <= 8'h00;
      seen_rst <= 1'b0;
   endtask

   task automatic wait_done();
      int n;
      n = 0;
      while (lnk.busy !== 1'b1 && n < 20) begin
         @(posedge hclk);
         n++;
      end
      while (lnk.busy !== 1'b0 && n < 40) begin
         @(posedge hclk);
         n++;
      end
      if (n >= 40) chk(32'h1, 32'h0);
      repeat (4) @(posedge hclk);
   endtask

   initial begin
      repeat (20000) @(posedge hclk);
      fail_count++;
      report_and_stop();
   end

   initial begin
      logic [31:0] r;
      logic [8:0] ien;
      logic sel, cz;
      void'($urandom(73177));
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd_chk(xc_pkg::A_CTRL, 32'h2);
      rd_chk(8'h40, 32'h0);
      // ----------------------------------------
      // hardware activation per source
      // ----------------------------------------
      for (int i = 0; i < 8; i++) begin
         ien = (i == 0) ? 9'h000 : 9'($urandom);
         sel = (i == 0 || i == 7) ? 1'b1 : (i < 3) ? 1'b0 : 1'($urandom);
         cz = (i == 1) ? 1'b1 : (i < 3) ? 1'b0 : 1'($urandom);
         irq_select <= sel;
         count_zero <= cz;
         wr(xc_pkg::A_IEN, {23'h0, ien});
         wr(xc_pkg::A_ACT_SET, 32'h1 << i);
         kick(8'h1 << i, 8'h00);
         wait_done();
         chk(launch, {4'(i), 8'(i)});
         rd_chk(xc_pkg::A_ACT_EN, fires(sel, cz) ? 32'h0 : 32'h1 << i);
         chk(seen, fires(sel, cz) ? 32'h0 : 32'h1 << i);
         rd_chk(xc_pkg::A_STAT, fires(sel, cz) ? 32'h1 << i : 32'h0);
         chk(irq, fires(sel, cz) & ien[i]);
         kick(8'h00, 8'hff);
         wr(xc_pkg::A_ACT_CLR, 32'hff);
         wr(xc_pkg::A_ICLR, 32'h1ff);
      end
      // ----------------------------------------
      // software activation, all select combos
      // ----------------------------------------
      wr(xc_pkg::A_IEN, 32'h1ff);
      for (int k = 0; k < 4; k++) begin
         r = {23'h0, 1'b1, 8'($urandom)};
         irq_select <= k[0];
         count_zero <= k[1];
         kick(8'h00, 8'h00);
         wr(xc_pkg::A_SOFT, r);
         wait_done();
         chk(launch, {4'h8, r[7:0]});
         if (k != 0) begin
            rd_chk(xc_pkg::A_SOFT, r);
            rd_chk(xc_pkg::A_STAT, 32'h100);
            chk(irq, 1'b1);
            wr(xc_pkg::A_SOFT, 32'h0);
            wr(xc_pkg::A_ICLR, 32'h1ff);
            chk(lnk.soft_end_irq, 1'b0);
         end else begin
            chk(seen[8], 1'b1);
            bus(xc_pkg::A_SOFT, 1'b0, 32'h0, r);
            chk(r[8], 1'b0);
         end
      end
      // ----------------------------------------
      // module stop
      // ----------------------------------------
      irq_select <= 1'b1;
      wr(xc_pkg::A_ACT_SET, 32'h8);
      kick(8'h8, 8'h00);
      while (lnk.busy !== 1'b1) @(posedge hclk);
      wr(xc_pkg::A_CTRL, 32'h3);
      bus(xc_pkg::A_CTRL, 1'b0, 32'h0, r);
      chk(r[0], 1'b0);
      wait_done();
      kick(8'h00, 8'hff);
      wr(xc_pkg::A_ICLR, 32'h1ff);
      wr(xc_pkg::A_CTRL, 32'h3);
      rd_chk(xc_pkg::A_CTRL, 32'h3);
      wr(xc_pkg::A_ACT_SET, 32'h10);
      kick(8'h10, 8'h00);
      wait_done();
      rd_chk(xc_pkg::A_ACT_EN, 32'h10);
      wr(xc_pkg::A_CTRL, 32'h1);
      rd_chk(xc_pkg::A_CTRL, 32'h3);
      bus(xc_pkg::A_ACT_EN, 1'b0, 32'h0, r);
      wr(xc_pkg::A_ACT_EN, r | 32'h60);
      rd_chk(xc_pkg::A_ACT_EN, 32'h70);
      wr(xc_pkg::A_CTRL, 32'h2);
      wait_done();
      rd_chk(xc_pkg::A_ACT_EN, 32'h60);
      report_and_stop();
   end
endmodule
